// ---- design/bitstream_pkg.sv ----
// Package: constants shared by the modulator end and the filter end
package bitstream_pkg;
  localparam int          INPUT_W         = 16;
  localparam int          CHOP_DIV        = 32;
  localparam int          MARKER_PERIOD   = 128;
  localparam int          CARRIER_MHZ     = 480;
  localparam int          CORE_CLK_MHZ    = 100;
  localparam int          FIFO_WIDTH      = 16;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          FILTER_OSR      = 256;
  localparam int          ACC_W           = 32;
  localparam logic [15:0] CLIP_POS        = 16'h7FFF;
  localparam logic [15:0] CLIP_NEG        = 16'h8001;
  localparam logic [15:0] MID_CODE        = 16'h8000;
  localparam int          SETTLE_TIME_US  = 250;
  localparam int          SETTLE_CYCLES   = SETTLE_TIME_US * CORE_CLK_MHZ;
  localparam int          FAILSAFE_CYCLES = MARKER_PERIOD + 1;
  localparam logic [6:0]  MARKER_RST      = 7'h00;
  localparam logic [4:0]  CHOP_RST        = 5'h00;
endpackage : bitstream_pkg

// ---- design/bitstream_if.sv ----
// Interface: sample clock and one-bit stream between the two ends
`timescale 1ns/100ps
interface bitstream_if;
  logic sample_clock_in;
  logic stream_bit;
  modport modulator (input sample_clock_in, output stream_bit);
  modport filter    (output sample_clock_in, input stream_bit);
endinterface : bitstream_if

// ---- design/sync_fifo.sv ----
// Module: synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      level;
  wire              do_wr = ce_i & in_valid_i & in_ready_o;
  wire              do_rd = ce_i & out_valid_o & out_ready_i;
  assign level       = wr_ptr - rd_ptr;
  assign in_ready_o  = (level != (AW+1)'(DEPTH));
  assign out_valid_o = (level != '0);
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge core_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(do_wr);
      rd_ptr <= rd_ptr + (AW+1)'(do_rd);
    end
  end
endmodule : sync_fifo

// ---- design/modulator_end.sv ----
// Module: behavioural second-order delta-sigma modulator output side
// Behaviour
// - Chopper period is 32 sample clocks
// - Second-order loop, 1-bit feedback next clock
// - Zero input gives half ones
// - Plus 1 V input gives 90 percent ones
// - Minus 1 V input gives 10 percent ones
// - Clip at plus or minus 1.25 V
// - Opposite marker bit every 128 cycles clipped
// - Ones density follows linear clip formula
// - Stream changes only on rising sample edge
// - Filter captures on same rising edge
// - Filter drives sample clock continuously; filter_end stops it while clk_run_i is low
// - Paused clock freezes stream at last level
// - Filter waits settle interval after restart
// - One keyed as carrier burst, zero none
// - Missing high-side supply gives steady zeros
// - Filter watches 129 cycles for supply loss
// - Sample clock between 5 and 21 MHz
`timescale 1ns/100ps
module modulator_end
  import bitstream_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic signed [15:0] analog_in_i,
  input  wire logic               high_side_supply_i,
  output logic                    chop_phase_o,
  output logic                    carrier_on_o,
  bitstream_if.modulator          link
);
  // Input is signed code: full scale 7FFF equals 1.25 V clip point
  logic              s1;
  logic              s2;
  logic              s3;
  logic              clk_lvl;
  logic              stream;
  logic              fb;
  logic signed [23:0] int1;
  logic signed [23:0] int2;
  logic [6:0]        marker_cnt;
  logic [4:0]        chop_cnt;
  logic              supply_ok;
  logic              sup1;
  logic              sup2;
  logic              sup3;
  ////////////////////////////////////////////////////////////////////
  wire               rise       = s2 & s3 & ~clk_lvl;
  wire               fall       = ~s2 & ~s3 & clk_lvl;
  wire signed [23:0] vin        = 24'(analog_in_i);
  wire signed [23:0] fb_level   = fb ? 24'sh007FFF : -24'sh007FFF;
  wire signed [23:0] next_int1  = int1 + vin - fb_level;
  wire signed [23:0] next_int2  = int2 + next_int1 - fb_level;
  wire               clip_pos   = (analog_in_i >= $signed(CLIP_POS));
  wire               clip_neg   = (analog_in_i <= $signed(CLIP_NEG));
  wire               marker_now = (marker_cnt == 7'(MARKER_PERIOD - 1));
  wire               loop_bit   = ~next_int2[23];
  wire               next_bit   = !supply_ok ? 1'b0 :
                                  clip_pos ? ~marker_now :
                                  clip_neg ? marker_now : loop_bit;
  ////////////////////////////////////////////////////////////////////
  // Three flops on the pin clock; a pause simply yields no edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      clk_lvl <= 1'b0;
      sup1 <= 1'b0;
      sup2 <= 1'b0;
      sup3 <= 1'b0;
      supply_ok <= 1'b0;
    end else if (ce_i) begin
      s1 <= link.sample_clock_in;
      s2 <= s1;
      s3 <= s2;
      sup1 <= high_side_supply_i;
      sup2 <= sup1;
      sup3 <= sup2;
      // Supply pin is asynchronous; only a settled level is taken
      if (sup2 == sup3) begin
        supply_ok <= sup3;
      end
      if (rise || fall) begin
        clk_lvl <= ~clk_lvl;
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stream <= 1'b0;
      fb <= 1'b0;
      int1 <= '0;
      int2 <= '0;
      marker_cnt <= MARKER_RST;
      chop_cnt <= CHOP_RST;
    end else if (ce_i && rise) begin
      stream <= next_bit;
      fb <= next_bit;
      int1 <= (clip_pos || clip_neg || !supply_ok) ? '0 : next_int1;
      int2 <= (clip_pos || clip_neg || !supply_ok) ? '0 : next_int2;
      marker_cnt <= marker_cnt + 7'h01;
      chop_cnt <= chop_cnt + 5'h01;
    end
  end
  assign link.stream_bit = stream;
  // Counter wraps every 32 rises, so its top bit is the chop square wave
  assign chop_phase_o    = chop_cnt[4];
  assign carrier_on_o    = stream;
endmodule : modulator_end

// ---- design/filter_end.sv ----
// Module: sample clock source, stream capture, decimator and supply check
`timescale 1ns/100ps
module filter_end
  import bitstream_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_CYCLES,
  parameter int CLK_HALF   = 3
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        clk_run_i,
  output logic [15:0]      code_o,
  output logic             code_valid_o,
  input  wire logic        code_ready_i,
  output logic             settled_o,
  output logic             supply_lost_o,
  bitstream_if.filter      link
);
  logic [3:0]       div_cnt;
  logic             sclk;
  logic [15:0]      zero_run;
  logic [31:0]      settle_cnt;
  logic [ACC_W-1:0] ones;
  logic [8:0]       nsamp;
  logic [15:0]      word;
  logic             word_valid;
  logic             lost;
  ////////////////////////////////////////////////////////////////////
  // Clock is 100 MHz / 6, within the 5 to 21 MHz window
  wire half_done  = (div_cnt == 4'(CLK_HALF - 1));
  wire sclk_rise  = clk_run_i & half_done & ~sclk;
  wire settled    = (settle_cnt >= 32'(SETTLE_CNT));
  wire last_samp  = (nsamp == 9'(FILTER_OSR - 1));
  wire fifo_ready;
  // 256 ones would overflow 16 bits, so that one case saturates
  wire [ACC_W-1:0] ones_total    = ones + ACC_W'(link.stream_bit);
  wire [15:0]      full_word     = 16'(ones_total << 8);
  wire [15:0]      scaled        = (ones_total >= ACC_W'(FILTER_OSR)) ? 16'hFFFF : full_word;
  // Saturating, so a long supply loss never wraps the run back to zero
  wire [15:0]      next_zero_run = (zero_run == 16'hFFFF) ? zero_run : zero_run + 16'h1;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      div_cnt <= '0;
      sclk <= 1'b0;
    end else if (ce_i && clk_run_i) begin
      div_cnt <= half_done ? 4'h0 : div_cnt + 4'h1;
      if (half_done) begin
        sclk <= ~sclk;
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      settle_cnt <= '0;
    end else if (ce_i) begin
      if (!clk_run_i) begin
        settle_cnt <= '0;
      end else if (!settled) begin
        settle_cnt <= settle_cnt + 32'h1;
      end
    end
  end
  // Captured at the edge we raise; stream is stable from the previous one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ones <= '0;
      nsamp <= '0;
      word <= MID_CODE;
      word_valid <= 1'b0;
      zero_run <= '0;
      lost <= 1'b0;
    end else if (ce_i) begin
      if (word_valid && fifo_ready) begin
        word_valid <= 1'b0;
      end
      if (sclk_rise) begin
        zero_run <= link.stream_bit ? 16'h0 : next_zero_run;
        lost <= !link.stream_bit && (zero_run >= 16'(FAILSAFE_CYCLES - 1));
        if (last_samp) begin
          // Ones count over 256 samples times 256; held word lost if FIFO full
          word <= scaled;
          word_valid <= settled;
          ones <= '0;
          nsamp <= '0;
        end else begin
          ones <= ones_total;
          nsamp <= nsamp + 9'h1;
        end
      end
    end
  end
  sync_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) i_sync_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (word),
    .in_valid_i  (word_valid),
    .in_ready_o  (fifo_ready),
    .out_data_o  (code_o),
    .out_valid_o (code_valid_o),
    .out_ready_i (code_ready_i)
  );
  assign link.sample_clock_in = sclk;
  assign settled_o            = settled;
  assign supply_lost_o        = lost;
endmodule : filter_end

// ---- verification/bitstream_chk.sv ----
// Checker: link and modulator output assertions
`timescale 1ns/100ps
module bitstream_chk (
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire logic               sample_clock_in,
  input wire logic               stream_bit,
  input wire logic               carrier_on_o,
  input wire logic               chop_phase_o,
  input wire logic               high_side_supply_i,
  input wire logic signed [15:0] analog_in_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] rises;
  wire        pos_clip = analog_in_i == 16'h7FFF;
  wire        neg_clip = analog_in_i == 16'h8001;
  ////////////////////////////////////////
  // Core-domain count, so flips lag rises by the sync delay
  always_ff @(posedge core_clk_i)
    if (rst_i || $changed(chop_phase_o)) rises <= 8'h00;
    else if ($rose(sample_clock_in)) rises <= rises + 8'h01;
  // Half of the 32-clock chop period lies between two flips
  a_chop_every_32: assert property ($changed(chop_phase_o) |-> rises == 8'h10)
    else $error("chop spacing");
  a_sclk_low_phase: assert property ($fell(sample_clock_in) |-> (!sample_clock_in) [*3])
    else $error("sample clock low too short");
  // Sync plus register puts each update four core cycles after a rise
  a_stream_on_rise: assert property ($changed(stream_bit) |->
    $past(sample_clock_in, 4) && !$past(sample_clock_in, 5))
    else $error("stream moved off rise");
  a_carrier_is_bit: assert property (carrier_on_o == stream_bit)
    else $error("carrier differs");
  a_failsafe_zero: assert property ((!high_side_supply_i) [*8] ##1 (!high_side_supply_i) [*8]
    |-> !stream_bit) else $error("stream not zero");
  a_freeze_hold: assert property ($stable(sample_clock_in) [*8] |-> $stable(stream_bit))
    else $error("stream moved while frozen");
  a_neg_marker: assert property (neg_clip [*8] ##1 (neg_clip && $rose(stream_bit))
    |-> ##[5:7] $fell(stream_bit)) else $error("negative marker");
  a_pos_marker: assert property (pos_clip [*8] ##1 (pos_clip && $fell(stream_bit))
    |-> ##[5:7] $rose(stream_bit)) else $error("positive marker");
  c_neg_marker: cover property (neg_clip && $rose(stream_bit));
  c_pos_marker: cover property (pos_clip && $fell(stream_bit));
  c_chop_flip: cover property ($changed(chop_phase_o));
endmodule : bitstream_chk

// ---- verification/isolated_bitstream_modulator_output_bench.sv ----
// Testbench: both link ends joined, stimulus and checks
`timescale 1ns/100ps
module isolated_bitstream_modulator_output_bench
  import bitstream_pkg::*;
;
  logic               core_clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic signed [15:0] analog_in_i = 16'h0000;
  logic               high_side_supply_i = 1'b1;
  logic               clk_run_i = 1'b1;
  logic               ce_i = 1'b1;
  logic               code_ready_i = 1'b0;
  logic               chop_phase_o, carrier_on_o, code_valid_o, settled_o, supply_lost_o;
  logic [15:0]        code_o, got;
  int                 fail_count = 0, checks = 0, cycles = 0;
  bitstream_if lnk ();
  modulator_end i_modulator_end (.core_clk_i, .rst_i, .ce_i, .analog_in_i,
    .high_side_supply_i, .chop_phase_o, .carrier_on_o, .link(lnk.modulator));
  // Short settle count keeps restart checks quick
  filter_end #(.SETTLE_CNT(50)) i_filter_end (.core_clk_i, .rst_i, .ce_i, .clk_run_i,
    .code_o, .code_valid_o, .code_ready_i, .settled_o, .supply_lost_o, .link(lnk.filter));
  bitstream_chk i_bitstream_chk (.core_clk_i, .rst_i, .sample_clock_in(lnk.sample_clock_in),
    .stream_bit(lnk.stream_bit), .carrier_on_o, .chop_phase_o, .high_side_supply_i, .analog_in_i);
  ////////////////////////////////////////
  initial forever #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic check(input logic ok, input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic pop();
    int n;
    n = 0;
    tick(1);
    while (code_valid_o !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    check(code_valid_o === 1'b1, {15'h0, code_valid_o}, 16'h0001);
    got = code_o;
    code_ready_i = 1'b1;
    tick(1);
    code_ready_i = 1'b0;
  endtask : pop
  // First two words may straddle the change, so they are skipped
  task automatic level(input logic [15:0] a, input logic [15:0] e);
    analog_in_i = a;
    repeat (3) pop();
    check(got >= e - 16'h01FF && got <= e + 16'h01FF, got, e);
  endtask : level
  task automatic freeze();
    clk_run_i = 1'b0;
    tick(20);
    got = {15'h0, lnk.stream_bit};
    tick(200);
    check(lnk.stream_bit === got[0], {15'h0, lnk.stream_bit}, got);
    clk_run_i = 1'b1;
    tick(5);
    check(settled_o === 1'b0, {15'h0, settled_o}, 16'h0000);
    tick(60);
    check(settled_o === 1'b1, {15'h0, settled_o}, 16'h0001);
  endtask : freeze
  // Enable drops just after a stream update, so none is left pending
  task automatic hold_enable();
    @(negedge lnk.sample_clock_in);
    tick(1);
    ce_i = 1'b0;
    got = {14'h0, lnk.sample_clock_in, lnk.stream_bit};
    tick(100);
    check({lnk.sample_clock_in, lnk.stream_bit} === got[1:0],
      {14'h0, lnk.sample_clock_in, lnk.stream_bit}, got);
    ce_i = 1'b1;
  endtask : hold_enable
  task automatic supply_loss();
    high_side_supply_i = 1'b0;
    tick(900);
    check(supply_lost_o === 1'b1 && lnk.stream_bit === 1'b0,
      {15'h0, supply_lost_o}, 16'h0001);
    high_side_supply_i = 1'b1;
  endtask : supply_loss
  // A held word may slip in once space frees, hence one extra allowed
  task automatic fill_drain();
    int n;
    n = 0;
    tick(28000);
    // Clock stopped so no fresh word lands while draining
    clk_run_i = 1'b0;
    while (code_valid_o === 1'b1 && n < 20) begin
      pop();
      n++;
    end
    check(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1, n[15:0], 16'(FIFO_DEPTH));
  endtask : fill_drain
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    tick(10);
    rst_i = 1'b0;
    level(16'h0000, 16'h8000);
    level(16'h6666, 16'hE666);
    freeze();
    hold_enable();
    level(16'h999A, 16'h1999);
    level(16'h3333, 16'hB333);
    level(16'h7FFF, 16'hFE00);
    level(16'h8001, 16'h0200);
    check(supply_lost_o === 1'b0, {15'h0, supply_lost_o}, 16'h0000);
    analog_in_i = 16'h0000;
    supply_loss();
    fill_drain();
    results();
  end
endmodule : isolated_bitstream_modulator_output_bench
